//--- logic/scvr_pkg.sv
// Purpose: Shared constants and types for the common control and vector registers
// Assumes: Word register index 0 is the selection register, index 1 the diagnostic one
// Notes:   Block size, register indices and device codes are named here once
package scvr_pkg;
   // --------------------------------------------------------------
   // Register block decode
   // --------------------------------------------------------------
   localparam int SCVR_BLOCK_WORDS = 16;
   localparam logic [3:0] SCVR_IDX_SELECT = 4'h0;
   localparam logic [3:0] SCVR_IDX_DIAG = 4'h1;

   // --------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------
   localparam int SCVR_CODE_HI = 15;
   localparam int SCVR_CODE_LO = 12;
   localparam int SCVR_VEC_HI = 7;

   // --------------------------------------------------------------
   // Device codes
   // --------------------------------------------------------------
   localparam logic [3:0] SCVR_CODE_ASYNC = 4'h8;
   localparam logic [3:0] SCVR_CODE_ASYNC_PRN = 4'ha;
   localparam logic [3:0] SCVR_CODE_SYNC_PAR = 4'hd;
   localparam logic [3:0] SCVR_CODE_SYNC_PRN = 4'he;

   // --------------------------------------------------------------
   // Diagnostic commands and answers
   // --------------------------------------------------------------
   localparam logic [7:0] SCVR_CMD_RESTART = 8'haa;
   localparam logic [7:0] SCVR_CMD_REVISION = 8'h2a;
   localparam logic [7:0] SCVR_CMD_PARITY = 8'h55;
   localparam logic [7:0] SCVR_SELFTEST_OK = 8'h80;
   localparam logic [15:0] SCVR_RESTART_ADDR = 16'h0000;
   localparam logic [7:0] SCVR_VEC_STEP = 8'h04;
   localparam logic [15:0] SCVR_ZERO_WORD = 16'h0000;

   // Unit availability carried to the rest of the device
   typedef struct packed {
      logic async_en;
      logic sync_en;
      logic parallel_port_unit_en;
      logic printer_unit_en;
   } scvr_units_s;

   // Eight floating vectors
   typedef logic [7:0][7:0] scvr_vectors_t;
endpackage

//--- logic/scvr_vector_gen.sv
// Purpose: Derives the eight floating interrupt vectors from the base
// Assumes: Base in the low byte of the selection register
// Notes:   Pure combinational, one adder per vector, each fed from the base
`timescale 1ns/1ps
module scvr_vector_gen
   import scvr_pkg::*;
(
   // Base vector
   input wire logic [7:0] base,
   // Derived vectors
   output scvr_vectors_t vectors
);
   // --------------------------------------------------------------
   // Vector spacing
   // --------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_vec
         // Base plus four per step, sync rx first, spare last
         assign vectors[gi] = 8'(base + 8'(gi) * SCVR_VEC_STEP); // see RULE_01
      end
   endgenerate
endmodule // scvr_vector_gen

//--- logic/scvr_regs.sv
// Purpose: Common selection, vector and diagnostic registers of the controller
// Assumes: One bus cycle per access strobe, byte address decoded to block and word here
// Notes:   Self-test result reported by the sequencer via selftest_done
//
// Overview of operation
// RULE_01 - Eight vectors are derived from the base, four apart, sync rx first, spare last.
// RULE_02 - The top four bits of the selection register hold the unit-set device code.
// RULE_03 - Codes 1000, 1010, 1101 and 1110 pick the four valid unit combinations.
// RULE_04 - Bits eleven to eight of the selection register read zero and are written zero.
// RULE_05 - The low byte of the selection register is the read/write base vector.
// RULE_06 - The written diagnostic high byte selects the diagnostic function.
// RULE_07 - Any read of the diagnostic register clears its low byte.
// RULE_08 - A forced parity error darkens the lamp, halts sequencing and locks access until reset.
// RULE_09 - Writing AA restarts execution at location zero and runs the self test.
// RULE_10 - After writing 2A a read of the diagnostic high byte returns the BCD revision.
// RULE_11 - A passed self test leaves a completion code in the diagnostic high byte.
// RULE_12 - The unit registers fill one sixteen-word block whose base comes from a switch pack.
// RULE_13 - Word-only registers ignore address bit zero and take byte writes as word writes.
// RULE_14 - A byte write to either half of the selection register updates only its low byte.
// RULE_15 - Selection switches are sampled once after reset; later code writes may replace it.
// RULE_16 - An unknown diagnostic command value changes nothing; the code still latches it into the diagnostic high byte.
`timescale 1ns/1ps
module scvr_regs
   import scvr_pkg::*;
#(
   parameter int ADDR_W = 18,
   parameter logic [7:0] FW_REVISION = 8'h12 // arbitrary BCD revision
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Host bus cycle
   input wire logic bus_sel,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic word_write_cycle,
   input wire logic byte_write_cycle,
   input wire logic read_cycle,
   input wire logic [15:0] bus_wdata,
   output logic [15:0] bus_rdata,
   output logic bus_ack,
   output logic unit_reg_sel,
   output logic [3:0] unit_reg_idx,
   output logic unit_byte_lane,
   // Switch inputs
   input wire logic [ADDR_W-1:5] block_base_switch_pack,
   input wire logic [3:0] unit_select_switch,
   // Sequencer link
   input wire logic selftest_done,
   input wire logic [7:0] maint_low_data,
   input wire logic maint_low_load,
   output logic seq_restart,
   output logic [15:0] seq_restart_addr,
   output logic seq_halt,
   // Status and configuration
   output logic status_led,
   output scvr_units_s units,
   output scvr_vectors_t vectors
);
   // --------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------
   logic [3:0] sw_meta_ff;
   logic [3:0] sw_sync_ff;
   logic [ADDR_W-1:5] base_meta_ff;
   logic [ADDR_W-1:5] base_sync_ff;

   // Two stages on switch levels
   // No reset, so the levels are settled when reset ends and the code sample sees them
   always_ff @(posedge core_clk) begin
      sw_meta_ff <= unit_select_switch;
      sw_sync_ff <= sw_meta_ff;
      base_meta_ff <= block_base_switch_pack;
      base_sync_ff <= base_meta_ff;
   end

   // --------------------------------------------------------------
   // Address decode
   // --------------------------------------------------------------
   logic in_block;
   logic [3:0] word_idx;
   logic access_ok;
   logic wr_any;
   logic rd_sel;
   logic rd_diag;
   logic wr_sel_word;
   logic wr_sel_byte;
   logic wr_diag;
   logic halted_ff;

   // Sixteen-word block at the switch base, bit zero dropped
   assign in_block = bus_sel && (bus_addr[ADDR_W-1:5] == base_sync_ff); // see RULE_12
   assign word_idx = bus_addr[4:1]; // see RULE_13
   assign access_ok = in_block && !halted_ff; // see RULE_08
   assign wr_any = word_write_cycle || byte_write_cycle;
   assign rd_sel = access_ok && read_cycle && (word_idx == SCVR_IDX_SELECT);
   assign rd_diag = access_ok && read_cycle && (word_idx == SCVR_IDX_DIAG);
   assign wr_sel_word = access_ok && word_write_cycle && (word_idx == SCVR_IDX_SELECT);
   assign wr_sel_byte = access_ok && byte_write_cycle && (word_idx == SCVR_IDX_SELECT);
   // Diagnostic register is word-only: byte write acts as word write
   assign wr_diag = access_ok && wr_any && (word_idx == SCVR_IDX_DIAG); // see RULE_13

   // Unit registers pass on with their own lane info
   assign unit_reg_sel = access_ok && (read_cycle || wr_any) && (word_idx > SCVR_IDX_DIAG);
   assign unit_reg_idx = word_idx;
   assign unit_byte_lane = bus_addr[0];
   // No answer while locked, so the cycle times out at the host
   assign bus_ack = access_ok && (read_cycle || wr_any); // see RULE_08

   // --------------------------------------------------------------
   // Selection register
   // --------------------------------------------------------------
   logic [3:0] code_ff;
   logic [7:0] vec_base_ff;
   logic sampled_ff;

   function automatic logic code_valid(input logic [3:0] c);
      code_valid = (c == SCVR_CODE_ASYNC) || (c == SCVR_CODE_ASYNC_PRN) ||
                   (c == SCVR_CODE_SYNC_PAR) || (c == SCVR_CODE_SYNC_PRN);
   endfunction

   // Code: sampled once after reset, then only word writes of valid codes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         code_ff <= SCVR_CODE_ASYNC;
         sampled_ff <= 1'b0;
      end else if (!sampled_ff) begin
         sampled_ff <= 1'b1; // see RULE_15
         code_ff <= sw_sync_ff; // see RULE_15
      end else if (wr_sel_word && code_valid(bus_wdata[SCVR_CODE_HI:SCVR_CODE_LO])) begin
         code_ff <= bus_wdata[SCVR_CODE_HI:SCVR_CODE_LO]; // see RULE_02
      end
   end

   // Base vector: word or byte write of either half loads the low byte
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         vec_base_ff <= 8'h00;
      end else if (wr_sel_word) begin
         vec_base_ff <= bus_wdata[SCVR_VEC_HI:0]; // see RULE_05
      end else if (wr_sel_byte) begin
         // Byte data rides on the lane that was addressed
         vec_base_ff <= bus_addr[0] ? bus_wdata[15:8] : bus_wdata[7:0]; // see RULE_14
      end
   end

   // Unit set from code
   always_comb begin
      units = '0;
      unique case (code_ff) // see RULE_03
         SCVR_CODE_ASYNC: units.async_en = 1'b1;
         SCVR_CODE_ASYNC_PRN: begin
            units.async_en = 1'b1;
            units.printer_unit_en = 1'b1;
         end
         SCVR_CODE_SYNC_PAR: begin
            units.async_en = 1'b1;
            units.sync_en = 1'b1;
            units.parallel_port_unit_en = 1'b1;
         end
         SCVR_CODE_SYNC_PRN: begin
            units.async_en = 1'b1;
            units.sync_en = 1'b1;
            units.printer_unit_en = 1'b1;
         end
         default: units = '0;
      endcase
   end

   scvr_vector_gen u_vec (
      .base(vec_base_ff),
      .vectors(vectors)
   );

   // --------------------------------------------------------------
   // Diagnostic register
   // --------------------------------------------------------------
   logic [7:0] diag_hi_ff;
   logic [7:0] diag_lo_ff;

   // High byte: command latch, revision and self-test answers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         diag_hi_ff <= 8'h00;
      end else if (wr_diag) begin
         if (bus_wdata[15:8] == SCVR_CMD_REVISION) begin
            diag_hi_ff <= FW_REVISION; // see RULE_10
         end else begin
            diag_hi_ff <= bus_wdata[15:8]; // see RULE_06
         end
      end else if (selftest_done) begin
         diag_hi_ff <= SCVR_SELFTEST_OK; // see RULE_11
      end
   end

   // Low byte: maintenance data, cleared by any read; load wins over clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         diag_lo_ff <= 8'h00;
      end else if (maint_low_load) begin
         diag_lo_ff <= maint_low_data;
      end else if (rd_diag) begin
         diag_lo_ff <= 8'h00; // see RULE_07
      end
   end

   // --------------------------------------------------------------
   // Diagnostic commands
   // --------------------------------------------------------------
   // Parity-error lock until reset
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         halted_ff <= 1'b0;
      end else if (wr_diag && bus_wdata[15:8] == SCVR_CMD_PARITY) begin
         halted_ff <= 1'b1; // see RULE_08
      end
   end

   // Restart pulse; unknown commands fall through untouched
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         seq_restart <= 1'b1;
      end else begin
         seq_restart <= wr_diag && (bus_wdata[15:8] == SCVR_CMD_RESTART); // see RULE_09
      end
   end
   // see RULE_16: only the three named commands act above

   assign seq_restart_addr = SCVR_RESTART_ADDR; // see RULE_09
   assign seq_halt = halted_ff;
   assign status_led = !halted_ff; // see RULE_08

   // --------------------------------------------------------------
   // Read data
   // --------------------------------------------------------------
   // Reserved bits read as zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_rdata <= SCVR_ZERO_WORD;
      end else if (rd_sel) begin
         bus_rdata <= {code_ff, 4'h0, vec_base_ff}; // see RULE_04
      end else if (rd_diag) begin
         bus_rdata <= {diag_hi_ff, diag_lo_ff};
      end
   end

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   AST_LOCK_NO_ACK: assert property (@(posedge core_clk) disable iff (rst) // see RULE_08
      halted_ff |-> !bus_ack) else $error("access answered while locked");
   AST_LOCK_STAYS: assert property (@(posedge core_clk) disable iff (rst) // see RULE_08
      $rose(halted_ff) |=> halted_ff [*8]) else $error("lock released early");
   AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (rst) // see RULE_04
      $past(rd_sel) |-> bus_rdata[11:8] == 4'h0) else $error("reserved bits not zero");
   AST_BYTE_KEEPS_CODE: assert property (@(posedge core_clk) disable iff (rst) // see RULE_14
      sampled_ff && wr_sel_byte |=> $stable(code_ff)) else $error("byte write changed code");
   AST_LOW_CLEARED: assert property (@(posedge core_clk) disable iff (rst) // see RULE_07
      rd_diag && !maint_low_load |=> diag_lo_ff == 8'h00) else $error("low byte not cleared");
   AST_RESTART: assert property (@(posedge core_clk) disable iff (rst) // see RULE_09
      wr_diag && bus_wdata[15:8] == SCVR_CMD_RESTART |=> seq_restart) else $error("no restart");
   AST_REVISION: assert property (@(posedge core_clk) disable iff (rst) // see RULE_10
      wr_diag && bus_wdata[15:8] == SCVR_CMD_REVISION |=> diag_hi_ff == FW_REVISION)
      else $error("revision not loaded");
   AST_SELFTEST: assert property (@(posedge core_clk) disable iff (rst) // see RULE_11
      selftest_done && !wr_diag |=> diag_hi_ff == SCVR_SELFTEST_OK) else $error("no pass code");
   AST_VECTOR_STEP: assert property (@(posedge core_clk) disable iff (rst) // see RULE_01
      vectors[7] == 8'(vectors[0] + 8'h1c)) else $error("vector spacing wrong");
   AST_CODE_VALID: assert property (@(posedge core_clk) disable iff (rst) // see RULE_03
      sampled_ff && $past(sampled_ff) && $changed(code_ff) |-> code_valid(code_ff))
      else $error("invalid code stored");

   // --------------------------------------------------------------
   // Write, load and read-back assertions
   // --------------------------------------------------------------
   // Register writes, switch sample, diagnostic read-back and maintenance load
   AST_CODE_WRITE: assert property (@(posedge core_clk) disable iff (rst) // see RULE_02
      sampled_ff && wr_sel_word && code_valid(bus_wdata[SCVR_CODE_HI:SCVR_CODE_LO])
      |=> code_ff == $past(bus_wdata[SCVR_CODE_HI:SCVR_CODE_LO]))
      else $error("code not taken");
   AST_VEC_WRITE: assert property (@(posedge core_clk) disable iff (rst) // see RULE_05
      wr_sel_word |=> vec_base_ff == $past(bus_wdata[SCVR_VEC_HI:0]))
      else $error("base vector not taken");
   AST_BYTE_LANE: assert property (@(posedge core_clk) disable iff (rst) // see RULE_14
      wr_sel_byte && bus_addr[0] |=> vec_base_ff == $past(bus_wdata[15:8]))
      else $error("high lane byte not taken");
   AST_SAMPLE_ONCE: assert property (@(posedge core_clk) disable iff (rst) // see RULE_15
      !sampled_ff |=> sampled_ff && code_ff == $past(sw_sync_ff))
      else $error("switch code not sampled");
   AST_RDATA_DIAG: assert property (@(posedge core_clk) disable iff (rst) // see RULE_06
      rd_diag |=> bus_rdata[15:8] == $past(diag_hi_ff))
      else $error("command byte not returned");
   AST_LOW_LOAD: assert property (@(posedge core_clk) disable iff (rst) // see RULE_07
      maint_low_load |=> diag_lo_ff == $past(maint_low_data))
      else $error("maintenance byte not loaded");
   // Diagnostic commands
   AST_BYTE_WR_DIAG: assert property (@(posedge core_clk) disable iff (rst) // see RULE_13
      wr_diag && byte_write_cycle && bus_wdata[15:8] == SCVR_CMD_REVISION
      |=> diag_hi_ff == FW_REVISION) else $error("byte write not taken as word");
   AST_PARITY_LOCK: assert property (@(posedge core_clk) disable iff (rst) // see RULE_08
      wr_diag && bus_wdata[15:8] == SCVR_CMD_PARITY |=> halted_ff && !status_led)
      else $error("parity command did not lock");
   AST_UNKNOWN_CMD: assert property (@(posedge core_clk) disable iff (rst) // see RULE_16
      wr_diag && bus_wdata[15:8] != SCVR_CMD_RESTART && bus_wdata[15:8] != SCVR_CMD_PARITY
      |=> !seq_restart && $stable(halted_ff)) else $error("unknown command acted");
   AST_RESTART_PULSE: assert property (@(posedge core_clk) disable iff (rst) // see RULE_09
      seq_restart && !wr_diag |=> !seq_restart)
      else $error("restart pulse too long");
endmodule // scvr_regs

//--- testbench/scvr_host_model.sv
// Purpose: Host processor model issuing word, byte and read cycles
// Assumes: Called just after a falling edge of core_clk
// Notes:   Released address and data lines show inverted values so stale data never matches
`timescale 1ns/1ps
module scvr_host_model (
   // Clock and answer
   input wire logic core_clk,
   input wire logic bus_ack,
   // Bus cycle
   output logic bus_sel,
   output logic [17:0] bus_addr,
   output logic word_write_cycle,
   output logic byte_write_cycle,
   output logic read_cycle,
   output logic [15:0] bus_wdata
);
   // Idle bus at time zero
   initial begin
      bus_sel = 1'b0;
      bus_addr = 18'h00000;
      word_write_cycle = 1'b0;
      byte_write_cycle = 1'b0;
      read_cycle = 1'b0;
      bus_wdata = 16'h0000;
   end

   // One cycle: kind 0 read, 1 word write, 2 byte write; ack wait bounded
   task automatic acc(input int kind, input logic [17:0] a, input logic [15:0] d,
                      output logic ok);
      int n;
      ok = 1'b0;
      // One idle edge so back-to-back calls never retoggle a line in one step
      @(negedge core_clk);
      bus_sel = 1'b1;
      bus_addr = a;
      read_cycle = (kind == 0);
      word_write_cycle = (kind == 1);
      byte_write_cycle = (kind == 2);
      bus_wdata = (kind == 1 && a[4:1] == 4'h0) ? {d[15:12], 4'h0, d[7:0]} : d;
      for (n = 0; n < 4 && ok !== 1'b1; n++) begin
         // Ack read once settled, ahead of the edge that takes the cycle
         #1 ok = bus_ack;
         @(posedge core_clk);
      end
      @(negedge core_clk);
      bus_sel = 1'b0;
      read_cycle = 1'b0;
      word_write_cycle = 1'b0;
      byte_write_cycle = 1'b0;
      bus_addr = ~bus_addr;
      bus_wdata = ~bus_wdata;
   endtask
endmodule // scvr_host_model

//--- testbench/scvr_regs_tb.sv
// Purpose: Self-checking bench for the common selection and diagnostic registers
// Assumes: Inputs change on the falling edge, read data checked from a queue
// Notes:   Revision parameter set to a value of our own
`timescale 1ns/1ps
module scvr_regs_tb;
   import scvr_pkg::*;
   localparam logic [7:0] REV = 8'h37;
   logic core_clk, rst, bus_sel, word_write_cycle, byte_write_cycle, read_cycle;
   logic bus_ack, unit_reg_sel, unit_byte_lane, selftest_done, maint_low_load;
   logic seq_restart, seq_halt, status_led, ok;
   logic rd_pend = 1'b0;
   logic [17:0] bus_addr;
   logic [17:5] blk;
   logic [15:0] bus_wdata, bus_rdata, seq_restart_addr;
   logic [3:0] unit_reg_idx, unit_select_switch;
   logic [7:0] maint_low_data, base, maint_d;
   logic [3:0] codes [4] = '{SCVR_CODE_ASYNC, SCVR_CODE_ASYNC_PRN, SCVR_CODE_SYNC_PAR,
                             SCVR_CODE_SYNC_PRN};
   logic [3:0] exp_units [4] = '{4'b1000, 4'b1001, 4'b1110, 4'b1101};
   logic [15:0] exp_q [$];
   scvr_units_s units;
   scvr_vectors_t vectors;
   int errors = 0;
   int compares = 0;

   scvr_regs #(.ADDR_W(18), .FW_REVISION(REV)) u_dut (
      .core_clk(core_clk), .rst(rst), .bus_sel(bus_sel), .bus_addr(bus_addr),
      .word_write_cycle(word_write_cycle), .byte_write_cycle(byte_write_cycle),
      .read_cycle(read_cycle), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .bus_ack(bus_ack), .unit_reg_sel(unit_reg_sel), .unit_reg_idx(unit_reg_idx),
      .unit_byte_lane(unit_byte_lane), .block_base_switch_pack(blk),
      .unit_select_switch(unit_select_switch), .selftest_done(selftest_done),
      .maint_low_data(maint_low_data), .maint_low_load(maint_low_load),
      .seq_restart(seq_restart), .seq_restart_addr(seq_restart_addr),
      .seq_halt(seq_halt), .status_led(status_led), .units(units), .vectors(vectors));

   scvr_host_model u_host (
      .core_clk(core_clk), .bus_ack(bus_ack), .bus_sel(bus_sel), .bus_addr(bus_addr),
      .word_write_cycle(word_write_cycle), .byte_write_cycle(byte_write_cycle),
      .read_cycle(read_cycle), .bus_wdata(bus_wdata));

   // 250 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (errors == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   function automatic logic [17:0] ad(input logic [4:0] off);
      return {blk, off};
   endfunction

   // Access inside the block; a missing or unexpected ack ends the run
   task automatic acc(input int kind, input logic [4:0] off, input logic [15:0] d,
                      input logic exp_ack);
      u_host.acc(kind, ad(off), d, ok);
      check(ok, exp_ack);
      if (ok !== exp_ack) report_and_stop();
   endtask

   task automatic rd(input logic [4:0] off, input logic [15:0] e);
      exp_q.push_back(e);
      acc(0, off, e, 1'b1);
   endtask

   task automatic do_reset();
      rst = 1'b1;
      repeat (5) @(negedge core_clk);
      check({bus_rdata[15:1], status_led & seq_restart}, 16'h0001);
      rst = 1'b0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   // Decode of every taken access into the unit pass-on
   always @(posedge core_clk) begin
      rd_pend <= bus_sel & read_cycle & bus_ack;
      if (bus_sel === 1'b1 && bus_ack === 1'b1) begin
         check({unit_reg_sel, unit_reg_sel ? unit_reg_idx : 4'h0, unit_byte_lane},
               {bus_addr[4:1] > 4'h1, bus_addr[4:1] > 4'h1 ? bus_addr[4:1] : 4'h0,
                bus_addr[0]});
      end
   end

   // Oldest noted read result against the data that appears
   always @(negedge core_clk) begin
      if (rd_pend === 1'b1) begin
         if (exp_q.size() == 0) check(bus_rdata, ~bus_rdata);
         else check(bus_rdata, exp_q.pop_front());
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(41883));
      rst = 1'b1;
      blk = 13'($urandom);
      unit_select_switch = SCVR_CODE_SYNC_PAR;
      selftest_done = 1'b0;
      maint_low_load = 1'b0;
      maint_low_data = 8'h00;
      do_reset();
      rd(5'h00, {SCVR_CODE_SYNC_PAR, 12'h000});
      check({12'h000, units}, 16'h000e);
      // Each valid code with a random base
      foreach (codes[i]) begin
         base = 8'($urandom);
         acc(1, 5'h00, {codes[i], 4'hf, base}, 1'b1);
         rd(5'h00, {codes[i], 4'h0, base});
         check({12'h000, units}, {12'h000, exp_units[i]});
         for (int v = 0; v < 8; v++) check(vectors[v], 8'(base + 8'(4 * v)));
      end
      // Byte writes to either half load only the vector
      base = 8'($urandom);
      acc(2, 5'h01, {base, 8'h00}, 1'b1);
      rd(5'h01, {SCVR_CODE_SYNC_PRN, 4'h0, base});
      acc(2, 5'h00, {8'h00, ~base}, 1'b1);
      rd(5'h00, {SCVR_CODE_SYNC_PRN, 4'h0, ~base});
      // Maintenance low byte cleared by any read
      maint_d = 8'($urandom);
      maint_low_data = maint_d;
      maint_low_load = 1'b1;
      @(negedge core_clk);
      maint_low_load = 1'b0;
      rd(5'h02, {8'h00, maint_d});
      rd(5'h02, 16'h0000);
      // Revision command sent as a byte write to the high half
      acc(2, 5'h03, {SCVR_CMD_REVISION, 8'h00}, 1'b1);
      rd(5'h02, {REV, 8'h00});
      // Unknown command starts no restart or lock and leaves the selection register alone
      acc(1, 5'h02, 16'h1300, 1'b1);
      check({seq_restart, seq_halt, status_led}, 3'b001);
      rd(5'h00, {SCVR_CODE_SYNC_PRN, 4'h0, ~base});
      // Restart command and self test report
      acc(1, 5'h02, {SCVR_CMD_RESTART, 8'h00}, 1'b1);
      check({seq_restart, seq_restart_addr}, {1'b1, SCVR_RESTART_ADDR});
      selftest_done = 1'b1;
      @(negedge core_clk);
      selftest_done = 1'b0;
      check(seq_restart, 1'b0);
      rd(5'h02, {SCVR_SELFTEST_OK, 8'h00});
      // Unit words pass on, outside the block nothing answers
      acc(1, 5'h0a, 16'($urandom), 1'b1);
      acc(2, 5'h1f, 16'($urandom), 1'b1);
      u_host.acc(1, {blk + 13'h1, 5'h02}, {SCVR_CMD_RESTART, 8'h00}, ok);
      check({ok, seq_restart}, 2'b00);
      // Parity command locks the device until reset
      acc(1, 5'h02, {SCVR_CMD_PARITY, 8'h00}, 1'b1);
      repeat (2) @(negedge core_clk);
      check({seq_halt, status_led}, 2'b10);
      acc(0, 5'h00, 16'h0000, 1'b0);
      unit_select_switch = SCVR_CODE_ASYNC_PRN;
      do_reset();
      check({seq_halt, status_led}, 2'b01);
      rd(5'h00, {SCVR_CODE_ASYNC_PRN, 12'h000});
      check({12'h000, units}, 16'h0009);
      repeat (2) @(negedge core_clk);
      check(16'(exp_q.size()), 16'h0000);
      report_and_stop();
   end
endmodule // scvr_regs_tb
